// file: hw/mcu_interrupt_controller.sv
// interrupt controller: request flags, enables, priority groups and vectoring for the core
// assumes the core presents register accesses and instruction-cycle strobes on mclk,
// and that peripheral request inputs are synchronous to mclk
//
// Overview of operation
// - eleven sources arbitrated over four priority levels
// - active service preempted only by strictly higher level
// - return_from_irq ends service, releases its level
// - flags set regardless of source enable
// - acknowledge by forcing long_call to vector
// - withhold during equal service, return, enable writes
// - global enable zero blocks every acknowledge
// - main enable bits: uart_a, timers, pin irqs
// - soc enables bits one-five, uart_b bit zero
// - pin type: zero low level, one falling
// - soc2/soc3 polarity: zero falling, one rising
// - soc request bits one-five hold flags
// - timer, pin and soc flags clear on vectoring
// - timer service acks pulse when routine called
// - source2 pulse OR rising; source3 busy falling
// - source4 supply change; source5 eeprom/spi manual
// - source6 transfer, second, minute, temperature events
// - sources five and six inputs inverted
// - each sub-source has its own enable
// - sub-flags clear by writing zero only
// - sub-flag bank bit layout as documented
// - groups one-three pair core and soc sources, group zero pin 0 and uart_b
// - group four uart_a/soc5, group five soc6
// - group level is high bit then low bit
// - fixed polling order within one level
// - vector addresses per source
`include "irq_ctrl_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module mcu_interrupt_controller (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port from the core
  input wire irq_ctrl_pkg::reg_req_type reg_req,
  output logic [7:0] reg_rdata,
  // instruction cycle from the core
  input wire logic inst_boundary,
  input wire logic inst_is_return,
  // call request to the core
  output irq_ctrl_pkg::irq_call_type irq_call,
  output logic tmr0_service_ack,
  output logic tmr1_service_ack,
  // core-internal sources
  input wire logic pin_irq0_n,
  input wire logic pin_irq1_n,
  input wire logic tmr0_overflow,
  input wire logic tmr1_overflow,
  input wire logic uart_a_irq,
  input wire logic uart_b_irq,
  // on-chip sources
  input wire logic [3:0] compute_pulse,
  input wire logic compute_busy,
  input wire logic [2:0] supply_state,
  input wire logic eeprom_busy,
  input wire logic spi_event,
  input wire logic transfer_busy,
  input wire logic rtc_second_tick,
  input wire logic rtc_minute_tick,
  input wire logic clock_temp_event
);

  localparam int NSRC = `NUM_SOURCES;

  logic [7:0] timer_pin_ctrl_q, irq_enable_main_q, irq_enable_soc_q, irq_enable_uart_b_q;
  logic [7:0] prio_low_bits_q, prio_high_bits_q, soc_irq_polarity_ctrl_q, soc_irq_request_q;
  logic [7:0] sub_flag_bank_a_q, sub_flag_bank_b_q, sub_enable_bank_a_q, sub_enable_bank_b_q;
  logic tmr0_flag_q, tmr1_flag_q;
  logic pin0_q, pin1_q, pulse_or_q, busy_q, soc5_q, soc6_q, eeprom_q, spi_q, xfer_q;
  logic [2:0] supply_q;
  logic [3:0] active_q;
  logic ack_q;
  logic [3:0] ack_src_q;

  function automatic logic hit(input logic [15:0] a);
    hit = reg_req.wr && (reg_req.addr == a);
  endfunction

  // group of each source in polling order: 0,0,1,1,2,2,3,3,4,4,5
  function automatic logic [2:0] group_of(input logic [3:0] s);
    group_of = 3'(s >> 1);
  endfunction

  function automatic logic [15:0] vector_of(input logic [3:0] s);
    case (s)
      4'h0: vector_of = `VEC_PIN_IRQ0;
      4'h1: vector_of = `VEC_UART_B;
      4'h2: vector_of = `VEC_TMR0;
      4'h3: vector_of = `VEC_SOC_BASE;
      4'h4: vector_of = `VEC_PIN_IRQ1;
      4'h5: vector_of = 16'(`VEC_SOC_BASE + `VEC_SOC_STEP);
      4'h6: vector_of = `VEC_TMR1;
      4'h7: vector_of = 16'(`VEC_SOC_BASE + 2 * `VEC_SOC_STEP);
      4'h8: vector_of = `VEC_UART_A;
      4'h9: vector_of = 16'(`VEC_SOC_BASE + 3 * `VEC_SOC_STEP);
      default: vector_of = 16'(`VEC_SOC_BASE + 4 * `VEC_SOC_STEP);
    endcase
  endfunction

  function automatic logic [3:0] src_idx(input irq_ctrl_pkg::source_type s);
    src_idx = 4'(s);
  endfunction

  // edge and level detection
  logic pin0_ev, pin1_ev, soc2_ev, soc3_ev, soc4_ev, soc5_ev, soc6_ev;
  logic pulse_or, soc5_in, soc6_in;
  logic [7:0] sub_a_set, sub_b_set;
  assign pulse_or = |compute_pulse;
  // soc sources 5 and 6 only see rising edges, so falling-active signals go in inverted
  assign soc5_in = ~(eeprom_busy | spi_event);
  assign soc6_in = ~(transfer_busy | rtc_second_tick | rtc_minute_tick | clock_temp_event);
  assign pin0_ev = timer_pin_ctrl_q[`BIT_PIN_IRQ0_TYPE] ? (pin0_q && !pin_irq0_n) : !pin_irq0_n;
  assign pin1_ev = timer_pin_ctrl_q[`BIT_PIN_IRQ1_TYPE] ? (pin1_q && !pin_irq1_n) : !pin_irq1_n;
  assign soc2_ev = soc_irq_polarity_ctrl_q[`BIT_SOC_IRQ2_POLARITY] ? (!pulse_or_q && pulse_or)
                   : (pulse_or_q && !pulse_or);
  assign soc3_ev = soc_irq_polarity_ctrl_q[`BIT_SOC_IRQ3_POLARITY] ? (!busy_q && compute_busy)
                   : (busy_q && !compute_busy);
  assign soc4_ev = supply_state != supply_q;
  assign soc5_ev = !soc5_q && soc5_in;
  assign soc6_ev = !soc6_q && soc6_in;

  always_comb begin
    sub_a_set = 8'h00;
    sub_b_set = 8'h00;
    sub_a_set[`BIT_A_TRANSFER] = xfer_q && !transfer_busy;
    sub_a_set[`BIT_A_SECOND] = rtc_second_tick;
    sub_a_set[`BIT_A_MINUTE] = rtc_minute_tick;
    sub_a_set[`BIT_A_TEMP] = clock_temp_event;
    sub_a_set[`BIT_A_PULSE_Y] = compute_pulse[0];
    sub_a_set[`BIT_A_PULSE_X] = compute_pulse[1];
    sub_a_set[`BIT_A_EEPROM] = eeprom_q && !eeprom_busy;
    sub_b_set[`BIT_B_PULSE_V] = compute_pulse[2];
    sub_b_set[`BIT_B_PULSE_W] = compute_pulse[3];
    sub_b_set[`BIT_B_SPI] = !spi_q && spi_event;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin0_q <= 1'b1;
      pin1_q <= 1'b1;
      pulse_or_q <= 1'b0;
      busy_q <= 1'b0;
      soc5_q <= 1'b1;
      soc6_q <= 1'b1;
      eeprom_q <= 1'b0;
      spi_q <= 1'b0;
      xfer_q <= 1'b0;
      supply_q <= 3'h0;
    end else begin
      pin0_q <= pin_irq0_n;
      pin1_q <= pin_irq1_n;
      pulse_or_q <= pulse_or;
      busy_q <= compute_busy;
      soc5_q <= soc5_in;
      soc6_q <= soc6_in;
      eeprom_q <= eeprom_busy;
      spi_q <= spi_event;
      xfer_q <= transfer_busy;
      supply_q <= supply_state;
    end
  end

  // plain control registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_enable_main_q <= `REG_RESET;
      irq_enable_soc_q <= `REG_RESET;
      irq_enable_uart_b_q <= `REG_RESET;
      prio_low_bits_q <= `REG_RESET;
      prio_high_bits_q <= `REG_RESET;
      soc_irq_polarity_ctrl_q <= `REG_RESET;
      sub_enable_bank_a_q <= `REG_RESET;
      sub_enable_bank_b_q <= `REG_RESET;
    end else begin
      if (hit(`ADDR_IRQ_ENABLE_MAIN)) irq_enable_main_q <= reg_req.wdata & `MASK_IRQ_ENABLE_MAIN;
      if (hit(`ADDR_IRQ_ENABLE_SOC)) irq_enable_soc_q <= reg_req.wdata & `MASK_IRQ_ENABLE_SOC;
      if (hit(`ADDR_IRQ_ENABLE_UART_B)) irq_enable_uart_b_q <= reg_req.wdata & `MASK_IRQ_ENABLE_UART_B;
      if (hit(`ADDR_PRIO_LOW_BITS)) prio_low_bits_q <= reg_req.wdata & `MASK_PRIO;
      if (hit(`ADDR_PRIO_HIGH_BITS)) prio_high_bits_q <= reg_req.wdata & `MASK_PRIO;
      if (hit(`ADDR_SOC_IRQ_POLARITY_CTRL)) soc_irq_polarity_ctrl_q <= reg_req.wdata & `MASK_POLARITY;
      if (hit(`ADDR_SUB_ENABLE_BANK_A)) sub_enable_bank_a_q <= reg_req.wdata & `MASK_SUB_A;
      if (hit(`ADDR_SUB_ENABLE_BANK_B)) sub_enable_bank_b_q <= reg_req.wdata & `MASK_SUB_B;
    end
  end

  // auto-clear per source on vectoring
  logic [NSRC-1:0] vec_clr;
  always_comb begin
    vec_clr = '0;
    if (ack_q) vec_clr[ack_src_q] = 1'b1;
  end

  // timer_pin_ctrl: type bits writable, flags set by hardware, cleared by software or vectoring
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      timer_pin_ctrl_q <= `REG_RESET;
      tmr0_flag_q <= 1'b0;
      tmr1_flag_q <= 1'b0;
    end else begin
      logic [7:0] t;
      t = timer_pin_ctrl_q;
      if (hit(`ADDR_TIMER_PIN_CTRL)) begin
        t = (t & ~`MASK_TIMER_PIN_CTRL) | (reg_req.wdata & `MASK_TIMER_PIN_CTRL);
        tmr0_flag_q <= reg_req.wdata[`BIT_TMR0_FLAG];
        tmr1_flag_q <= reg_req.wdata[`BIT_TMR1_FLAG];
      end
      if (vec_clr[src_idx(irq_ctrl_pkg::src_pin_irq0)]) t[`BIT_PIN_IRQ0_FLAG] = 1'b0;
      if (vec_clr[src_idx(irq_ctrl_pkg::src_pin_irq1)]) t[`BIT_PIN_IRQ1_FLAG] = 1'b0;
      if (vec_clr[src_idx(irq_ctrl_pkg::src_tmr0)]) tmr0_flag_q <= 1'b0;
      if (vec_clr[src_idx(irq_ctrl_pkg::src_tmr1)]) tmr1_flag_q <= 1'b0;
      // set wins over any clear in the same cycle
      if (pin0_ev) t[`BIT_PIN_IRQ0_FLAG] = 1'b1;
      if (pin1_ev) t[`BIT_PIN_IRQ1_FLAG] = 1'b1;
      if (tmr0_overflow) tmr0_flag_q <= 1'b1;
      if (tmr1_overflow) tmr1_flag_q <= 1'b1;
      timer_pin_ctrl_q <= t;
    end
  end

  // soc_irq_request: bits 1..5 are flags 2..6
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      soc_irq_request_q <= `REG_RESET;
    end else begin
      logic [7:0] r;
      logic [4:0] ev;
      r = soc_irq_request_q;
      if (hit(`ADDR_SOC_IRQ_REQUEST)) r = reg_req.wdata & `MASK_SOC_REQUEST;
      if (vec_clr[src_idx(irq_ctrl_pkg::src_soc_irq2)]) r[1] = 1'b0;
      if (vec_clr[src_idx(irq_ctrl_pkg::src_soc_irq3)]) r[2] = 1'b0;
      if (vec_clr[src_idx(irq_ctrl_pkg::src_soc_irq4)]) r[3] = 1'b0;
      if (vec_clr[src_idx(irq_ctrl_pkg::src_soc_irq5)]) r[4] = 1'b0;
      if (vec_clr[src_idx(irq_ctrl_pkg::src_soc_irq6)]) r[5] = 1'b0;
      ev = {soc6_ev, soc5_ev, soc4_ev, soc3_ev, soc2_ev};
      r[5:1] = r[5:1] | ev;
      soc_irq_request_q <= r;
    end
  end

  // sub-flags: writing 0 clears, 1 leaves alone, new event wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sub_flag_bank_a_q <= `REG_RESET;
      sub_flag_bank_b_q <= `REG_RESET;
    end else begin
      logic [7:0] a, b;
      a = sub_flag_bank_a_q;
      b = sub_flag_bank_b_q;
      if (hit(`ADDR_SUB_FLAG_BANK_A)) a = a & reg_req.wdata;
      if (hit(`ADDR_SUB_FLAG_BANK_B)) b = b & reg_req.wdata;
      sub_flag_bank_a_q <= (a | sub_a_set) & `MASK_SUB_A;
      sub_flag_bank_b_q <= (b | sub_b_set) & `MASK_SUB_B;
    end
  end

  // pending computation
  logic [NSRC-1:0] pending;
  logic [7:0] sub_a_act, sub_b_act;
  logic sub2_ok, sub5_ok, sub6_ok;
  assign sub_a_act = sub_flag_bank_a_q & sub_enable_bank_a_q;
  assign sub_b_act = sub_flag_bank_b_q & sub_enable_bank_b_q;
  assign sub2_ok = sub_a_act[`BIT_A_PULSE_X] | sub_a_act[`BIT_A_PULSE_Y]
                   | sub_b_act[`BIT_B_PULSE_V] | sub_b_act[`BIT_B_PULSE_W];
  assign sub5_ok = sub_a_act[`BIT_A_EEPROM] | sub_b_act[`BIT_B_SPI];
  assign sub6_ok = sub_a_act[`BIT_A_TRANSFER] | sub_a_act[`BIT_A_SECOND]
                   | sub_a_act[`BIT_A_MINUTE] | sub_a_act[`BIT_A_TEMP];

  always_comb begin
    pending = '0;
    pending[0] = timer_pin_ctrl_q[`BIT_PIN_IRQ0_FLAG] & irq_enable_main_q[`BIT_PIN_IRQ0_EN];
    pending[1] = uart_b_irq & irq_enable_uart_b_q[0];
    pending[2] = tmr0_flag_q & irq_enable_main_q[`BIT_TMR0_EN];
    pending[3] = soc_irq_request_q[1] & irq_enable_soc_q[1] & sub2_ok;
    pending[4] = timer_pin_ctrl_q[`BIT_PIN_IRQ1_FLAG] & irq_enable_main_q[`BIT_PIN_IRQ1_EN];
    pending[5] = soc_irq_request_q[2] & irq_enable_soc_q[2];
    pending[6] = tmr1_flag_q & irq_enable_main_q[`BIT_TMR1_EN];
    pending[7] = soc_irq_request_q[3] & irq_enable_soc_q[3];
    pending[8] = uart_a_irq & irq_enable_main_q[`BIT_UART_A_EN];
    pending[9] = soc_irq_request_q[4] & irq_enable_soc_q[4] & sub5_ok;
    pending[10] = soc_irq_request_q[5] & irq_enable_soc_q[5] & sub6_ok;
    if (!irq_enable_main_q[`BIT_GLOBAL_IRQ_ENABLE]) pending = '0;
  end

  // arbitration: highest level wins, polling order within a level
  logic win_valid;
  logic [3:0] win_src;
  logic [1:0] win_lvl;
  always_comb begin
    logic [2:0] g;
    logic [1:0] l;
    g = 3'h0;
    l = 2'h0;
    win_valid = 1'b0;
    win_src = 4'h0;
    win_lvl = 2'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      g = group_of(4'(i));
      l = {prio_high_bits_q[g], prio_low_bits_q[g]};
      if (pending[i] && (!win_valid || l >= win_lvl)) begin
        win_valid = 1'b1;
        win_src = 4'(i);
        win_lvl = l;
      end
    end
  end

  // active-level stack, one bit per level, at most four nested services
  logic [1:0] top_lvl;
  logic any_active;
  assign any_active = |active_q;
  assign top_lvl = active_q[3] ? 2'd3 : active_q[2] ? 2'd2 : active_q[1] ? 2'd1 : 2'd0;

  logic block_write, can_ack;
  assign block_write = hit(`ADDR_IRQ_ENABLE_MAIN) || hit(`ADDR_IRQ_ENABLE_SOC)
                       || hit(`ADDR_IRQ_ENABLE_UART_B) || hit(`ADDR_PRIO_LOW_BITS)
                       || hit(`ADDR_PRIO_HIGH_BITS);
  assign can_ack = inst_boundary && win_valid && !inst_is_return && !block_write && !ack_q
                   && (!any_active || win_lvl > top_lvl);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      active_q <= 4'h0;
      ack_q <= 1'b0;
      ack_src_q <= 4'h0;
    end else begin
      ack_q <= can_ack;
      if (can_ack) ack_src_q <= win_src;
      if (inst_boundary && inst_is_return && any_active) active_q[top_lvl] <= 1'b0;
      else if (can_ack) active_q[win_lvl] <= 1'b1;
    end
  end

  // call request and timer acks registered
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_call <= '0;
      tmr0_service_ack <= 1'b0;
      tmr1_service_ack <= 1'b0;
    end else begin
      irq_call.long_call <= can_ack;
      irq_call.vector <= can_ack ? vector_of(win_src) : 16'h0000;
      irq_call.source <= can_ack ? win_src : 4'h0;
      tmr0_service_ack <= can_ack && win_src == src_idx(irq_ctrl_pkg::src_tmr0);
      tmr1_service_ack <= can_ack && win_src == src_idx(irq_ctrl_pkg::src_tmr1);
    end
  end

  // read mux
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        `ADDR_TIMER_PIN_CTRL: reg_rdata <= timer_pin_ctrl_q | {tmr1_flag_q, 1'b0, tmr0_flag_q, 5'h00};
        `ADDR_IRQ_ENABLE_UART_B: reg_rdata <= irq_enable_uart_b_q;
        `ADDR_IRQ_ENABLE_MAIN: reg_rdata <= irq_enable_main_q;
        `ADDR_PRIO_LOW_BITS: reg_rdata <= prio_low_bits_q;
        `ADDR_IRQ_ENABLE_SOC: reg_rdata <= irq_enable_soc_q;
        `ADDR_PRIO_HIGH_BITS: reg_rdata <= prio_high_bits_q;
        `ADDR_SOC_IRQ_REQUEST: reg_rdata <= soc_irq_request_q;
        `ADDR_SOC_IRQ_POLARITY_CTRL: reg_rdata <= soc_irq_polarity_ctrl_q;
        `ADDR_SUB_FLAG_BANK_A: reg_rdata <= sub_flag_bank_a_q;
        `ADDR_SUB_FLAG_BANK_B: reg_rdata <= sub_flag_bank_b_q;
        `ADDR_SUB_ENABLE_BANK_A: reg_rdata <= sub_enable_bank_a_q;
        `ADDR_SUB_ENABLE_BANK_B: reg_rdata <= sub_enable_bank_b_q;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule

`default_nettype wire

// file: hw/irq_ctrl_cfg.svh
// register addresses, bit positions, reset values and vector addresses for the interrupt controller
// assumes an 8-bit special register port and a 16-bit external register port on the core
`ifndef IRQ_CTRL_CFG_SVH
`define IRQ_CTRL_CFG_SVH

`define ADDR_TIMER_PIN_CTRL 16'h0088
`define ADDR_IRQ_ENABLE_UART_B 16'h009a
`define ADDR_IRQ_ENABLE_MAIN 16'h00a8
`define ADDR_PRIO_LOW_BITS 16'h00a9
`define ADDR_IRQ_ENABLE_SOC 16'h00b8
`define ADDR_PRIO_HIGH_BITS 16'h00b9
`define ADDR_SOC_IRQ_REQUEST 16'h00c0
`define ADDR_SOC_IRQ_POLARITY_CTRL 16'h00c8
`define ADDR_SUB_FLAG_BANK_A 16'h00e8
`define ADDR_SUB_FLAG_BANK_B 16'h00f8
`define ADDR_SUB_ENABLE_BANK_A 16'h2700
`define ADDR_SUB_ENABLE_BANK_B 16'h2701

`define REG_RESET 8'h00

// irq_enable_main bits, then register write masks
`define BIT_GLOBAL_IRQ_ENABLE 7
`define BIT_UART_A_EN 4
`define BIT_TMR1_EN 3
`define BIT_PIN_IRQ1_EN 2
`define BIT_TMR0_EN 1
`define BIT_PIN_IRQ0_EN 0
`define MASK_IRQ_ENABLE_MAIN 8'h9f
`define MASK_IRQ_ENABLE_SOC 8'h3e
`define MASK_IRQ_ENABLE_UART_B 8'h01
`define MASK_PRIO 8'h3f
`define MASK_POLARITY 8'h60
`define MASK_SOC_REQUEST 8'h3e
`define MASK_SUB_A 8'hf7
`define MASK_SUB_B 8'he0

// timer_pin_ctrl
`define BIT_TMR1_FLAG 7
`define BIT_TMR0_FLAG 5
`define BIT_PIN_IRQ1_FLAG 3
`define BIT_PIN_IRQ1_TYPE 2
`define BIT_PIN_IRQ0_FLAG 1
`define BIT_PIN_IRQ0_TYPE 0
`define MASK_TIMER_PIN_CTRL 8'h0f

// soc_irq_polarity_ctrl
`define BIT_SOC_IRQ3_POLARITY 6
`define BIT_SOC_IRQ2_POLARITY 5

// sub-flag / sub-enable banks
`define BIT_A_TRANSFER 0
`define BIT_A_SECOND 1
`define BIT_A_MINUTE 2
`define BIT_A_TEMP 4
`define BIT_A_PULSE_Y 5
`define BIT_A_PULSE_X 6
`define BIT_A_EEPROM 7
`define BIT_B_PULSE_V 5
`define BIT_B_PULSE_W 6
`define BIT_B_SPI 7

// vectors
`define VEC_PIN_IRQ0 16'h0003
`define VEC_TMR0 16'h000b
`define VEC_PIN_IRQ1 16'h0013
`define VEC_TMR1 16'h001b
`define VEC_UART_A 16'h0023
`define VEC_UART_B 16'h0083
`define VEC_SOC_BASE 16'h004b
`define VEC_SOC_STEP 16'h0008

`define NUM_SOURCES 11
`define NUM_GROUPS 6

`endif

// file: hw/irq_ctrl_pkg.sv
// types for the interrupt controller
// assumes irq_ctrl_cfg.svh holds the numbers
package irq_ctrl_pkg;

  // sources in polling order, index 0 polled first
  typedef enum logic [3:0] {
    src_pin_irq0, src_uart_b, src_tmr0, src_soc_irq2, src_pin_irq1, src_soc_irq3,
    src_tmr1, src_soc_irq4, src_uart_a, src_soc_irq5, src_soc_irq6
  } source_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic long_call;
    logic [15:0] vector;
    logic [3:0] source;
  } irq_call_type;

  typedef enum logic [1:0] {
    inst_idle, inst_exec
  } service_state_type;

endpackage

// file: test/irq_ctrl_properties.sv
// concurrent checks on the interrupt controller's call, ack and read ports
// assumes irq_ctrl_cfg.svh and irq_ctrl_pkg are compiled before this file
`include "irq_ctrl_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module irq_ctrl_properties (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire irq_ctrl_pkg::reg_req_type reg_req,
  input wire logic [7:0] reg_rdata,
  // core side
  input wire logic inst_boundary,
  input wire logic inst_is_return,
  input wire irq_ctrl_pkg::irq_call_type irq_call,
  input wire logic tmr0_service_ack,
  input wire logic tmr1_service_ack
);
  localparam logic [15:0] vtab [11] = '{16'h0003, 16'h0083, 16'h000b, 16'h004b, 16'h0013, 16'h0053,
    16'h001b, 16'h005b, 16'h0023, 16'h0063, 16'h006b};
  logic gie_q;
  wire logic call;
  wire logic en_wr;
  assign call = irq_call.long_call;
  assign en_wr = reg_req.wr && (reg_req.addr == `ADDR_IRQ_ENABLE_MAIN || reg_req.addr == `ADDR_IRQ_ENABLE_SOC
    || reg_req.addr == `ADDR_IRQ_ENABLE_UART_B || reg_req.addr == `ADDR_PRIO_LOW_BITS
    || reg_req.addr == `ADDR_PRIO_HIGH_BITS);

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // shadow of the global enable, updated on the same edge as the register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) gie_q <= 1'b0;
    else if (reg_req.wr && reg_req.addr == `ADDR_IRQ_ENABLE_MAIN) gie_q <= reg_req.wdata[7];
  end

  sequence s_return;
    inst_boundary && inst_is_return;
  endsequence
  sequence s_rd(logic [15:0] a);
    reg_req.rd && reg_req.addr == a;
  endsequence

  property p_call_pulse; call |=> !call; endproperty
  a_call_pulse: assert property (p_call_pulse) else $error("long_call longer than one cycle");
  property p_call_boundary; call |-> $past(inst_boundary); endproperty
  a_call_boundary: assert property (p_call_boundary) else $error("call without boundary");
  property p_no_call_return; s_return |=> !call; endproperty
  a_no_call_return: assert property (p_no_call_return) else $error("call after return");
  property p_no_call_en_wr; en_wr |=> !call; endproperty
  a_no_call_en_wr: assert property (p_no_call_en_wr) else $error("call after enable write");
  property p_global_off; call |-> $past(gie_q); endproperty
  a_global_off: assert property (p_global_off) else $error("call with global enable off");
  property p_vector; call |-> irq_call.vector == vtab[irq_call.source]; endproperty
  a_vector: assert property (p_vector) else $error("vector does not match source");
  property p_idle; !call |-> irq_call.vector == 16'h0000 && irq_call.source == 4'h0; endproperty
  a_idle: assert property (p_idle) else $error("vector not zero outside call");
  property p_ack0; tmr0_service_ack == (call && irq_call.source == irq_ctrl_pkg::src_tmr0); endproperty
  a_ack0: assert property (p_ack0) else $error("timer 0 ack mismatch");
  property p_ack1; tmr1_service_ack == (call && irq_call.source == irq_ctrl_pkg::src_tmr1); endproperty
  a_ack1: assert property (p_ack1) else $error("timer 1 ack mismatch");
  property p_main_unused; s_rd(`ADDR_IRQ_ENABLE_MAIN) |=> reg_rdata[6:5] == 2'b00; endproperty
  a_main_unused: assert property (p_main_unused) else $error("unused enable bits read set");
  property p_req_unused; s_rd(`ADDR_SOC_IRQ_REQUEST) |=> reg_rdata[7:6] == 2'b00 && !reg_rdata[0];
  endproperty
  a_req_unused: assert property (p_req_unused) else $error("unused request bits read set");
endmodule

bind mcu_interrupt_controller irq_ctrl_properties u_props (.mclk(mclk), .rst(rst), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .inst_boundary(inst_boundary), .inst_is_return(inst_is_return),
  .irq_call(irq_call), .tmr0_service_ack(tmr0_service_ack), .tmr1_service_ack(tmr1_service_ack));
`default_nettype wire

// file: test/core_model.sv
// behavioural processor core: instruction-cycle strobes and single return requests
// assumes the controller samples its strobes on the rising edge of mclk
`timescale 1ns/100ps
`default_nettype none

module core_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // return request from the bench
  input wire logic ret_req,
  // instruction cycle to the controller
  output logic inst_boundary,
  output logic inst_is_return
);
  logic pend_q;
  // one boundary every second cycle, one return per request so nesting is not unwound twice
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      inst_boundary <= 1'b0;
      inst_is_return <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      inst_boundary <= !inst_boundary;
      inst_is_return <= !inst_boundary && pend_q;
      pend_q <= ret_req || (pend_q && inst_boundary);
    end
  end
endmodule
`default_nettype wire

// file: test/testbench.sv
// self-checking bench: register table, every source's vector, enables and priority
// assumes irq_ctrl_cfg.svh, irq_ctrl_pkg and core_model are compiled first
`include "irq_ctrl_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHECK(nm, exp, got) samples_checked++; if ((got) !== (exp)) begin miscompares++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end

module testbench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ret_req = 1'b0;
  irq_ctrl_pkg::reg_req_type reg_req = '0;
  irq_ctrl_pkg::irq_call_type irq_call;
  logic [7:0] reg_rdata;
  logic inst_boundary, inst_is_return, tmr0_service_ack, tmr1_service_ack;
  logic pin_irq0_n = 1'b1, pin_irq1_n = 1'b1, tmr0_overflow = 1'b0, tmr1_overflow = 1'b0;
  logic uart_a_irq = 1'b0, uart_b_irq = 1'b0, compute_busy = 1'b0, eeprom_busy = 1'b0, transfer_busy = 1'b0;
  logic [3:0] compute_pulse = 4'h0;
  logic [2:0] supply_state = 3'h0;
  logic spi_event = 1'b0, rtc_second_tick = 1'b0, rtc_minute_tick = 1'b0, clock_temp_event = 1'b0;
  int miscompares = 0;
  int samples_checked = 0;
  logic [15:0] reg_addr [11] = '{16'h00a8, 16'h00b8, 16'h009a, 16'h00a9, 16'h00b9, 16'h00c8, 16'h2700,
    16'h2701, 16'h00e8, 16'h00f8, 16'h0100};
  logic [7:0] reg_mask [11] = '{8'h9f, 8'h3e, 8'h01, 8'h3f, 8'h3f, 8'h60, 8'hf7, 8'he0, 8'h00, 8'h00, 8'h00};
  logic [15:0] vec_tab [12] = '{16'h0003, 16'h0083, 16'h000b, 16'h004b, 16'h0013, 16'h0053, 16'h001b,
    16'h005b, 16'h0023, 16'h0063, 16'h006b, 16'h006b};
  logic [7:0] sub_tab [12] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h01, 8'h16};

  always #2 mclk = !mclk;

  core_model u_core (.mclk(mclk), .rst(rst), .ret_req(ret_req), .inst_boundary(inst_boundary),
    .inst_is_return(inst_is_return));
  mcu_interrupt_controller DUT (.mclk(mclk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .inst_boundary(inst_boundary), .inst_is_return(inst_is_return), .irq_call(irq_call),
    .tmr0_service_ack(tmr0_service_ack), .tmr1_service_ack(tmr1_service_ack), .pin_irq0_n(pin_irq0_n),
    .pin_irq1_n(pin_irq1_n), .tmr0_overflow(tmr0_overflow), .tmr1_overflow(tmr1_overflow),
    .uart_a_irq(uart_a_irq), .uart_b_irq(uart_b_irq), .compute_pulse(compute_pulse),
    .compute_busy(compute_busy), .supply_state(supply_state), .eeprom_busy(eeprom_busy),
    .spi_event(spi_event), .transfer_busy(transfer_busy), .rtc_second_tick(rtc_second_tick),
    .rtc_minute_tick(rtc_minute_tick), .clock_temp_event(clock_temp_event));

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge mclk);
    reg_req = '0;
    @(negedge mclk);
  endtask

  task automatic check_rd(input logic [15:0] a, input logic [7:0] e);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge mclk);
    reg_req = '0;
    @(negedge mclk);
    `CHECK("reg_rdata", e, reg_rdata)
  endtask

  // 16'hffff stands for no call expected in the window
  task automatic wait_call(input logic [15:0] exp);
    logic [15:0] got;
    got = 16'hffff;
    repeat (40) begin
      if (got === 16'hffff && irq_call.long_call === 1'b1) got = irq_call.vector;
      @(negedge mclk);
    end
    `CHECK("vector", exp, got)
    if (exp !== 16'hffff && got === 16'hffff) print_verdict();
  endtask

  task automatic do_ret();
    ret_req = 1'b1;
    @(negedge mclk);
    ret_req = 1'b0;
  endtask

  task automatic apply(input int i, input logic v);
    case (i)
      0: pin_irq0_n = !v;
      1: uart_b_irq = v;
      2: tmr0_overflow = v;
      3: compute_pulse[1] = v;
      4: pin_irq1_n = !v;
      5: compute_busy = v;
      6: tmr1_overflow = v;
      7: supply_state = {2'b00, v};
      8: uart_a_irq = v;
      9: {eeprom_busy, spi_event} = {2{v}};
      11: {rtc_second_tick, rtc_minute_tick, clock_temp_event} = {3{v}};
      default: transfer_busy = v;
    endcase
  endtask

  task automatic pulse2(input int a, input int b);
    apply(a, 1'b1);
    apply(b, 1'b1);
    @(negedge mclk);
    apply(a, 1'b0);
    apply(b, 1'b0);
  endtask

  initial begin
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    for (int i = 0; i < 11; i++) begin
      check_rd(reg_addr[i], 8'h00);
      wr(reg_addr[i], 8'hff);
      check_rd(reg_addr[i], reg_mask[i]);
      wr(reg_addr[i], 8'h00);
    end
    $display("registers done");
    wr(`ADDR_TIMER_PIN_CTRL, 8'h05);
    wr(`ADDR_SOC_IRQ_POLARITY_CTRL, 8'h20);
    wr(`ADDR_IRQ_ENABLE_SOC, 8'h3e);
    wr(`ADDR_IRQ_ENABLE_UART_B, 8'h01);
    wr(`ADDR_SUB_ENABLE_BANK_A, 8'hf7);
    wr(`ADDR_SUB_ENABLE_BANK_B, 8'he0);
    wr(`ADDR_IRQ_ENABLE_MAIN, 8'h9f);
    for (int i = 0; i < 12; i++) begin
      if (i == 1 || i == 8) apply(i, 1'b1);
      else pulse2(i, i);
      wait_call(vec_tab[i]);
      apply(i, 1'b0);
      wr(`ADDR_SUB_FLAG_BANK_A, 8'hff);
      check_rd(`ADDR_SUB_FLAG_BANK_A, sub_tab[i]);
      wr(`ADDR_SUB_FLAG_BANK_A, 8'h00);
      check_rd(`ADDR_TIMER_PIN_CTRL, 8'h05);
      check_rd(`ADDR_SOC_IRQ_REQUEST, 8'h00);
      do_ret();
    end
    $display("vectors done");
    wr(`ADDR_IRQ_ENABLE_MAIN, 8'h9d);
    pulse2(2, 2);
    wait_call(16'hffff);
    check_rd(`ADDR_TIMER_PIN_CTRL, 8'h25);
    wr(`ADDR_IRQ_ENABLE_MAIN, 8'h1f);
    wait_call(16'hffff);
    wr(`ADDR_IRQ_ENABLE_MAIN, 8'h9f);
    wait_call(`VEC_TMR0);
    do_ret();
    $display("enables done");
    wr(`ADDR_PRIO_HIGH_BITS, 8'h02);
    pulse2(0, 2);
    wait_call(`VEC_TMR0);
    wait_call(16'hffff);
    do_ret();
    wait_call(`VEC_PIN_IRQ0);
    do_ret();
    wr(`ADDR_PRIO_HIGH_BITS, 8'h00);
    pulse2(4, 2);
    wait_call(`VEC_TMR0);
    do_ret();
    wait_call(`VEC_PIN_IRQ1);
    do_ret();
    $display("priority done");
    rst = 1'b1;
    @(negedge mclk);
    rst = 1'b0;
    check_rd(`ADDR_IRQ_ENABLE_MAIN, `REG_RESET);
    print_verdict();
  end
endmodule
`default_nettype wire
